// file: logic/sccs_consts.vh
// Constants for the system clock select control block.
`ifndef SCCS_CONSTS_VH
`define SCCS_CONSTS_VH
`define SCCS_IDX_XTAL 12'h00a
`define SCCS_IDX_MODE 12'h010
`define SCCS_ADDR_XTAL (`SCCS_IDX_XTAL << 2)
`define SCCS_ADDR_MODE (`SCCS_IDX_MODE << 2)
`define SCCS_BOOT_WAIT 2'h2
`define SCCS_SRC_RESET_ONEHOT 8'h20
`define SCCS_XTAL_EN_BIT 7
`define SCCS_XTAL_DRV_HI 6
`define SCCS_XTAL_DRV_LO 5
`define SCCS_MODE_FAST_EN_BIT 4
`define SCCS_MODE_SLOW_EN_BIT 2
`define SCCS_MODE_DIV2 8'h34
`define SCCS_MODE_DIV4 8'h14
`define SCCS_MODE_DIV8 8'h3c
`define SCCS_MODE_DIV16 8'h1c
`define SCCS_MODE_DIV32 8'h7c
`define SCCS_MODE_SLOW 8'he4
`define SCCS_MODE_UNCAL 8'hf4
`define SCCS_OPT_DIV2 3'h0
`define SCCS_OPT_DIV4 3'h1
`define SCCS_OPT_DIV8 3'h2
`define SCCS_OPT_DIV16 3'h3
`define SCCS_OPT_DIV32 3'h4
`define SCCS_OPT_SLOW 3'h5
`define SCCS_OPT_OFF 3'h7
`define SCCS_SRC_DIV2 3'h0
`define SCCS_SRC_DIV4 3'h1
`define SCCS_SRC_DIV8 3'h2
`define SCCS_SRC_DIV16 3'h3
`define SCCS_SRC_DIV32 3'h4
`define SCCS_SRC_SLOW 3'h5
`define SCCS_SRC_XTAL 3'h6
`define SCCS_SRC_DIV64 3'h7
`endif

// file: logic/sccs_top.v
// System clock source selection, divider and oscillator enable control.
// Overview of operation
// - Divide-by-8 trim option makes the mode register read 0x3c after boot.
// - Divide-by-16 trim option makes the mode register read 0x1c after boot.
// - Divide-by-32 trim option makes the mode register read 0x7c after boot.
// - Slow trim option reads 0xe4, slow oscillator clocks, fast one disabled.
// - Any trimmed option: watchdog off, slow oscillator on, port A bit five input.
// - Untrimmed boot leaves mode untouched, watchdog on, slow or fast/64 clock.
// - Crystal control bit 7 switches the crystal oscillator on or off.
// - Crystal control bits 6:5 select low, middle or high drive.
// - A mode write changes source and divider at once, any time after boot.
// - Mode bit 4 enables the fast oscillator; cleared only after leaving it.
// - Mode bit 2 enables the slow oscillator; cleared only after leaving it.
// - 0x34 selects fast/2, 0x14 fast/4, both keep slow enabled.
// - 0xb4 or 0xb0 select the crystal with the fast oscillator kept on.
// - 0xa6 moves from slow to crystal; slow stays on until cleared.
// - 0xf4 moves from fast to slow; fast stays on until cleared.
`timescale 1ns/100ps
`include "sccs_consts.vh"
module sccs_top (
  // Clock and reset.
  input wire clk_i,
  input wire resetn_i,
  // APB slave.
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output wire pready_o,
  output reg [31:0] prdata_o,
  output wire pslverr_o,
  // Boot-time strap inputs.
  input wire [2:0] trim_option_i,
  input wire fast_boot_i,
  // Oscillator clocks in.
  input wire fast_rc_clk_i,
  input wire slow_rc_clk_i,
  input wire xtal_clk_i,
  // Oscillator controls and status out.
  output reg fast_rc_oscillator_en_o,
  output reg slow_rc_oscillator_en_o,
  output reg crystal_oscillator_en_o,
  output reg [1:0] crystal_drive_o,
  output reg fast_rc_trimmed_o,
  output reg watchdog_en_o,
  output reg port_a_bit_five_input_o,
  output reg [2:0] sys_src_o,
  output wire sys_clk_o
);

  // Strap synchronisers and boot state.
  reg [2:0] opt_s1;
  reg [2:0] opt_s2;
  reg fb_s1;
  reg fb_s2;
  reg booted;
  reg [1:0] boot_wait;
  reg [7:0] clock_mode_select;
  reg [7:0] crystal_osc_ctrl;
  reg [2:0] next_src;

  // Decode of mode bits 7:5 and 3 into a source code.
  function [2:0] sccs_decode;
    input [7:0] m;
    begin
      case ({m[7:5], m[3]})
        4'b0010: sccs_decode = `SCCS_SRC_DIV2;
        4'b0000: sccs_decode = `SCCS_SRC_DIV4;
        4'b0011: sccs_decode = `SCCS_SRC_DIV8;
        4'b0001: sccs_decode = `SCCS_SRC_DIV16;
        4'b0111: sccs_decode = `SCCS_SRC_DIV32;
        4'b1110: sccs_decode = `SCCS_SRC_SLOW;
        4'b1111: sccs_decode = `SCCS_SRC_SLOW;
        4'b1010: sccs_decode = `SCCS_SRC_XTAL;
        4'b1011: sccs_decode = `SCCS_SRC_XTAL;
        default: sccs_decode = `SCCS_SRC_DIV4;
      endcase
    end
  endfunction

  // Register select codes returned by the address decode.
  localparam [1:0] sel_none = 2'h0;
  localparam [1:0] sel_mode = 2'h1;
  localparam [1:0] sel_xtal = 2'h2;

  // Address decode shared by the write path and the read mux, so that both
  // always agree on which register an address names.
  function [1:0] sccs_reg_sel;
    input [11:0] a;
    begin
      if (a == `SCCS_ADDR_MODE) begin
        sccs_reg_sel = sel_mode;
      end else if (a == `SCCS_ADDR_XTAL) begin
        sccs_reg_sel = sel_xtal;
      end else begin
        sccs_reg_sel = sel_none;
      end
    end
  endfunction

  // No wait states: every access completes in its first access cycle.
  wire apb_wr = psel_i & penable_i & pwrite_i;
  wire [1:0] reg_sel = sccs_reg_sel(paddr_i);
  assign pready_o = 1'b1;
  assign pslverr_o = 1'b0;

  // Straps pass two flip-flops before use.
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      opt_s1 <= 3'h0;
      opt_s2 <= 3'h0;
      fb_s1 <= 1'b0;
      fb_s2 <= 1'b0;
    end else begin
      opt_s1 <= trim_option_i;
      opt_s2 <= opt_s1;
      fb_s1 <= fast_boot_i;
      fb_s2 <= fb_s1;
    end
  end

  // Boot load waits until the strap synchronisers hold live values; loading
  // earlier would take the synchronisers' reset contents for the straps.
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      boot_wait <= 2'h0;
    end else if (boot_wait != `SCCS_BOOT_WAIT) begin
      boot_wait <= boot_wait + 2'h1;
    end
  end
  wire boot_ready = (boot_wait == `SCCS_BOOT_WAIT);

  // Boot load, then register writes and source select.
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      booted <= 1'b0;
      clock_mode_select <= `SCCS_MODE_UNCAL;
      crystal_osc_ctrl <= 8'h00;
      fast_rc_trimmed_o <= 1'b0;
      watchdog_en_o <= 1'b1;
      port_a_bit_five_input_o <= 1'b1;
      sys_src_o <= `SCCS_SRC_SLOW;
    end else if (!booted && boot_ready) begin
      booted <= 1'b1;
      port_a_bit_five_input_o <= 1'b1;
      fast_rc_trimmed_o <= (opt_s2 != `SCCS_OPT_OFF);
      watchdog_en_o <= (opt_s2 == `SCCS_OPT_OFF);
      case (opt_s2)
        `SCCS_OPT_DIV2: clock_mode_select <= `SCCS_MODE_DIV2;
        `SCCS_OPT_DIV4: clock_mode_select <= `SCCS_MODE_DIV4;
        `SCCS_OPT_DIV8: clock_mode_select <= `SCCS_MODE_DIV8;
        `SCCS_OPT_DIV16: clock_mode_select <= `SCCS_MODE_DIV16;
        `SCCS_OPT_DIV32: clock_mode_select <= `SCCS_MODE_DIV32;
        `SCCS_OPT_SLOW: clock_mode_select <= `SCCS_MODE_SLOW;
        default: clock_mode_select <= clock_mode_select;
      endcase
      if (opt_s2 == `SCCS_OPT_OFF) begin
        sys_src_o <= fb_s2 ? `SCCS_SRC_SLOW : `SCCS_SRC_DIV64;
      end else if (opt_s2 == `SCCS_OPT_SLOW) begin
        sys_src_o <= `SCCS_SRC_SLOW;
      end else begin
        sys_src_o <= opt_s2;
      end
    end else if (booted) begin
      // Writes before boot are dropped so they cannot race the boot load.
      if (apb_wr && reg_sel == sel_mode) begin
        clock_mode_select <= pwdata_i[7:0];
        sys_src_o <= next_src;
      end else if (apb_wr && reg_sel == sel_xtal) begin
        crystal_osc_ctrl <= {pwdata_i[7:5], 5'h00};
      end
    end
  end

  // Source requested by the pending mode write.
  always @* begin
    next_src = sccs_decode(pwdata_i[7:0]);
  end

  // Oscillator enables follow their control bits.
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fast_rc_oscillator_en_o <= 1'b1;
      slow_rc_oscillator_en_o <= 1'b1;
      crystal_oscillator_en_o <= 1'b0;
      crystal_drive_o <= 2'h0;
    end else begin
      fast_rc_oscillator_en_o <= clock_mode_select[`SCCS_MODE_FAST_EN_BIT];
      slow_rc_oscillator_en_o <= clock_mode_select[`SCCS_MODE_SLOW_EN_BIT];
      crystal_oscillator_en_o <= crystal_osc_ctrl[`SCCS_XTAL_EN_BIT];
      crystal_drive_o <= crystal_osc_ctrl[`SCCS_XTAL_DRV_HI:`SCCS_XTAL_DRV_LO];
    end
  end

  // APB read mux, latched in the setup cycle so the data stands through the
  // whole access phase.
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prdata_o <= 32'h0;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      if (reg_sel == sel_mode) begin
        prdata_o <= {24'h0, clock_mode_select};
      end else if (reg_sel == sel_xtal) begin
        prdata_o <= {24'h0, crystal_osc_ctrl};
      end else begin
        prdata_o <= 32'h0;
      end
    end
  end

  // Fast oscillator divider chain, reset while the block is reset.
  // Bit k toggles at the fast clock divided by two to the power k plus one,
  // so every divided source shares one counter and stays phase related.
  reg [5:0] fdiv;
  always @(posedge fast_rc_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fdiv <= 6'h00;
    end else begin
      fdiv <= fdiv + 6'h01;
    end
  end

  // Glitch-free selection: each source has its own enable stage.
  wire [7:0] src_clk;
  assign src_clk[0] = fdiv[0];
  assign src_clk[1] = fdiv[1];
  assign src_clk[2] = fdiv[2];
  assign src_clk[3] = fdiv[3];
  assign src_clk[4] = fdiv[4];
  assign src_clk[5] = slow_rc_clk_i;
  assign src_clk[6] = xtal_clk_i;
  assign src_clk[7] = fdiv[5];
  wire [7:0] gate_neg;

  // One-hot copy of the source code: each source domain then synchronises a
  // single settled bit instead of decoding a three-bit word that is changing.
  reg [7:0] src_onehot;
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      src_onehot <= `SCCS_SRC_RESET_ONEHOT;
    end else begin
      src_onehot <= 8'h01 << sys_src_o;
    end
  end

  // Each source owns a two-flop request synchroniser and a gate that only
  // changes while its clock is low, so no pulse is ever cut short.
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_sel
      reg want_s1;
      reg want_s2;
      reg gate_q;
      wire others_on;
      // A source may open only after every other gate has closed.
      assign others_on = |(gate_neg & ~(8'h01 << g));
      always @(posedge src_clk[g] or negedge resetn_i) begin
        if (!resetn_i) begin
          want_s1 <= 1'b0;
          want_s2 <= 1'b0;
        end else begin
          want_s1 <= src_onehot[g] & ~others_on;
          want_s2 <= want_s1;
        end
      end
      // The gate moves on the falling edge, while its source is low.
      always @(negedge src_clk[g] or negedge resetn_i) begin
        if (!resetn_i) begin
          gate_q <= 1'b0;
        end else begin
          gate_q <= want_s2;
        end
      end
      assign gate_neg[g] = gate_q;
    end
  endgenerate
  assign sys_clk_o = |(src_clk & gate_neg);

endmodule // sccs_top

// file: bench/sccs_sva.sv
// Checker for the system clock select block.
`timescale 1ns/100ps
module sccs_sva (
  // Clock, reset and bus.
  input wire clk_i,
  input wire resetn_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [31:0] prdata_o,
  // Oscillator controls.
  input wire fast_rc_oscillator_en_o,
  input wire slow_rc_oscillator_en_o,
  input wire crystal_oscillator_en_o,
  input wire [1:0] crystal_drive_o,
  input wire [2:0] sys_src_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // Access-phase strobes: writes per register, reads at any address.
  wire wm = psel_i && penable_i && pwrite_i && paddr_i == 12'h040;
  wire wx = psel_i && penable_i && pwrite_i && paddr_i == 12'h028;
  wire rd = psel_i && penable_i && !pwrite_i;
  chk_fast_en: assert property (
    wm |=> ##1 fast_rc_oscillator_en_o == $past(pwdata_i[4], 2)) else $error("fast en");
  chk_slow_en: assert property (
    wm |=> ##1 slow_rc_oscillator_en_o == $past(pwdata_i[2], 2)) else $error("slow en");
  chk_xtal_en: assert property (
    wx |=> ##1 crystal_oscillator_en_o == $past(pwdata_i[7], 2)) else $error("xtal en");
  chk_xtal_drive: assert property (
    wx |=> ##1 crystal_drive_o == $past(pwdata_i[6:5], 2)) else $error("xtal drive");
  chk_to_slow: assert property (
    wm && pwdata_i[7:5] == 3'h7 |=> sys_src_o == 3'h5) else $error("slow source");
  chk_to_xtal: assert property (
    wm && pwdata_i[7:5] == 3'h5 |=> sys_src_o == 3'h6) else $error("xtal source");
  chk_unmapped_zero: assert property (
    rd && paddr_i != 12'h040 && paddr_i != 12'h028 |-> prdata_o == 32'h0) else $error("unmapped");
  chk_xtal_read: assert property (
    rd && paddr_i == 12'h028 |-> prdata_o[7:0] == {crystal_oscillator_en_o, crystal_drive_o, 5'h0})
    else $error("xtal read");
  // Main scenarios reached.
  cover property (wm ##1 sys_src_o == 3'h6);
  cover property (wx && pwdata_i[7]);
  cover property (rd && paddr_i == 12'h040);
endmodule // sccs_sva
bind sccs_top sccs_sva i_sccs_sva (.*);

// file: bench/test_system_clock_select_control.sv
// Self-checking bench for the system clock select block.
`timescale 1ns/100ps
module test_system_clock_select_control;
  logic clk_i = 1'h0, resetn_i = 1'h1, psel_i = 1'h0, penable_i = 1'h0, pwrite_i = 1'h0;
  logic fast_boot_i = 1'h0, fast_rc_clk_i = 1'h0, slow_rc_clk_i = 1'h0, xtal_clk_i = 1'h0;
  logic [11:0] paddr_i = 12'h0;
  logic [31:0] pwdata_i = 32'h0, q, e;
  logic [2:0] trim_option_i = 3'h0;
  wire pready_o, pslverr_o, fast_rc_oscillator_en_o, slow_rc_oscillator_en_o, sys_clk_o;
  wire crystal_oscillator_en_o, fast_rc_trimmed_o, watchdog_en_o, port_a_bit_five_input_o;
  wire [31:0] prdata_o;
  wire [1:0] crystal_drive_o;
  wire [2:0] sys_src_o;
  int n_fail = 0, cmp_count = 0;
  int n_edge = 0;
  logic [7:0] bm [7] = '{8'h34, 8'h14, 8'h3c, 8'h1c, 8'h7c, 8'he4, 8'hf4};
  logic [10:0] cd [10] = '{11'h034, 11'h114, 11'h23c, 11'h31c, 11'h47c, 11'h5e4, 11'h6b4,
    11'h6b0, 11'h6a6, 11'h5f4};
  sccs_top i_sccs_top (.*);
  // Control clock at 100 MHz.
  always #5 clk_i = ~clk_i;
  // Oscillators: fast 200 MHz, slow 25 MHz, crystal 62.5 MHz; some edges of each meet clk_i edges.
  always #2.5 fast_rc_clk_i = ~fast_rc_clk_i;
  always #20 slow_rc_clk_i = ~slow_rc_clk_i;
  always #8 xtal_clk_i = ~xtal_clk_i;
  // Counts rising edges of the system clock.
  always @(posedge sys_clk_o) n_edge++;
  // Prints the verdict and ends the run.
  task automatic summarize();
    if (n_fail == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Compares one result with its expected value.
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t %h %h", $time, got, exp);
    end
  endtask
  // Rising system clock edges expected in a 640 ns window for a source code.
  function automatic int edges(input logic [2:0] s);
    if (s == 3'h5) return 16;
    else if (s == 3'h6) return 40;
    else if (s == 3'h7) return 2;
    else return 64 >> s;
  endfunction
  // Lets a source switch settle, then counts system clock edges.
  task automatic clk_chk(input logic [2:0] s);
    int e0;
    repeat (200) @(posedge clk_i);
    e0 = n_edge;
    repeat (64) @(posedge clk_i);
    cmp(n_edge - e0, edges(s));
  endtask
  // One APB transfer, then one idle cycle; read data lands in q.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dw);
    int n;
    psel_i <= 1'h1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= dw;
    @(posedge clk_i);
    penable_i <= 1'h1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'h1 && n < 20);
    if (n == 20) begin
      n_fail++;
      summarize();
    end
    q = prdata_o;
    e = pslverr_o;
    psel_i <= 1'h0;
    penable_i <= 1'h0;
    @(posedge clk_i);
  endtask
  // Writes a mode value, then checks read-back, source and enables.
  task automatic mode(input logic [10:0] c);
    apb(1'h1, 12'h040, {24'h0, c[7:0]});
    apb(1'h0, 12'h040, 32'h0);
    cmp(q, {24'h0, c[7:0]});
    cmp(sys_src_o, c[10:8]);
    cmp(fast_rc_oscillator_en_o, c[4]);
    cmp(slow_rc_oscillator_en_o, c[2]);
    clk_chk(c[10:8]);
  endtask
  // Writes the crystal control, then checks read-back and outputs.
  task automatic xtal(input logic [7:0] x);
    apb(1'h1, 12'h028, {24'h0, x});
    apb(1'h0, 12'h028, 32'h0);
    cmp(q, {24'h0, x[7:5], 5'h0});
    cmp(crystal_oscillator_en_o, x[7]);
    cmp(crystal_drive_o, x[6:5]);
  endtask
  // Resets with one strap option and checks the boot state.
  task automatic boot(input int i);
    resetn_i <= 1'h0;
    trim_option_i <= i < 6 ? i[2:0] : 3'h7;
    fast_boot_i <= i == 7;
    repeat (3) @(posedge clk_i);
    resetn_i <= 1'h1;
    repeat (5) @(posedge clk_i);
    apb(1'h0, 12'h040, 32'h0);
    cmp(q, {24'h0, bm[i > 5 ? 6 : i]});
    cmp(watchdog_en_o, i > 5);
    cmp(fast_rc_trimmed_o, i < 6);
    cmp(slow_rc_oscillator_en_o, 1'h1);
    cmp(port_a_bit_five_input_o, 1'h1);
    cmp(fast_rc_oscillator_en_o, i != 5);
    cmp(sys_src_o, i < 6 ? i[2:0] : i == 7 ? 3'h5 : 3'h7);
    clk_chk(i < 6 ? i[2:0] : i == 7 ? 3'h5 : 3'h7);
  endtask
  // Boots strap options 0 to 5 with fast boot low, then option 7 with both fast boot values, then walks mode and crystal values.
  initial begin
    q = $urandom(98367);
    for (int i = 0; i < 8; i++) boot(i);
    xtal(8'he0);
    repeat (100) @(posedge clk_i);
    foreach (cd[k]) begin
      mode(cd[k]);
      // running oscillator kept on: fast enable flips only off the fast sources.
      mode(cd[k] ^ (11'($urandom) & (cd[k][10:8] > 3'h4 ? 11'h013 : 11'h003)));
    end
    for (int k = 0; k < 12; k++) xtal(k < 8 ? {k[2:0], 5'h0} : 8'($urandom));
    xtal(8'h00);
    apb(1'h1, 12'h100, 32'hff);
    apb(1'h0, 12'h100, 32'h0);
    cmp(q, 32'h0);
    cmp(e, 32'h0);
    summarize();
  end
endmodule // test_system_clock_select_control
